// ### rtl/dwc_debug_regs.sv
// Debug watch unit: control, status, vector trap and two watchpoints
`timescale 1ns/100ps
`default_nettype none
`include "dwc_map.svh"

// Operation
// [R1] Control bit 3 low compares instruction address, data and control buses.
// [R2] Debugger sets control mask bits 1:0 for instruction comparison.
// [R3] Control bit 8 gates the breakpoint output; it has no mask.
// [R4] Watchpoint 0 range input takes watchpoint 1 address comparator.
// [R5] Watchpoint 1 chain latch: enabled by address/control, loads data match.
// [R6] Chain latch clears on control value write and on reset.
// [R7] Control bit 5 compares each watchpoint's own external condition input.
// [R8] Control bit 4 compares instruction not-translate: 0 user, 1 privileged.
// [R9] Control bit 1 compares compressed state: 1 compressed, 0 normal.
// [R10] Debug control: step, interrupt disable, request, acknowledge bits.
// [R11] Status: scan write bit high writes, low reads five status bits.
// [R12] Status bit 4 shows the core's compressed state.
// [R13] Status bit 3 shows synchronised system access complete flag.
// [R14] Status bit 2 interrupt enable derives from synchronised acknowledge.
// [R15] Status bits 1:0 show synchronised request and acknowledge.
// [R16] Vector trap: fast irq7 irq6 res5 dabort4 pabort3 soft irq2 undef1 reset0.
// [R17] Mask bit one ignores the matching value bit; the code never applies control mask bit 3.
// [R18] Enabled vector trap forces debug entry on exception vector fetch.
// [R19] Single step: leave debug, run one instruction, re-enter debug.
// [R20] Match needs every unmasked address, data and control bit equal.
// [R21] Registers and chain latch clear while reset is held.
module dwc_debug_regs
(
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire dwc_pkg::dwc_scan_t   scan,
	output logic [31:0]               scanReadData,
	input  wire dwc_pkg::dwc_ibus_t   ibus,
	input  wire dwc_pkg::dwc_dbus_t   dbus,
	input  wire dwc_pkg::dwc_vecfetch_t vecFetch,
	input  wire logic                 instrRetired,
	input  wire logic                 external_condition_wp0,
	input  wire logic                 external_condition_wp1,
	input  wire logic                 debug_acknowledge,
	input  wire logic                 debug_request_in,
	input  wire logic                 system_access_complete,
	input  wire logic                 compressed_state_flag,
	output logic                      debug_request,
	output logic                      interrupt_disable,
	output logic                      single_step,
	output logic                      breakpoint,
	output logic                      chain_latch_out
);

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} dwc_step_t;

	logic [3:0]  debugControl;
	logic [4:0]  statusOverride;
	logic        statusWritten;
	logic [7:0]  exceptionVectorTrap;
	logic [3:0]  syncA;
	logic [3:0]  syncB;
	logic        ackPrev;
	logic [4:0]  liveStatus;
	logic [4:0]  debugStatus;
	logic        wrStrobe;
	logic [31:0] wp0Read;
	logic [31:0] wp1Read;
	logic        wp0ReadHit;
	logic        wp1ReadHit;
	logic        wp0Hit;
	logic        wp1Hit;
	logic        wp1Addr;
	logic        wp1Ctl;
	logic        wp1Data;
	logic        wp1CtlWrite;
	logic        vectorHit;
	logic        stepHit;
	logic [31:0] localRead;
	logic [31:0] localData;
	logic        readSelWp0;
	logic        readSelWp1;
	dwc_step_t   stepState;
	dwc_step_t   next_stepState;

	// ------------------------------------------------------------
	// Watchpoints
	// ------------------------------------------------------------
	// Unit 1 address match drives range of unit 0 [R4]
	// Chain latch output drives chain of unit 0 [R5]
	dwc_watch_unit u_wp0
	(
		.core_clk          (core_clk),
		.reset             (reset),
		.scan              (scan),
		.baseAddr          (`DWC_ADDR_WP0_AV),
		.ibus              (ibus),
		.dbus              (dbus),
		.rangeIn           (wp1Addr),
		.chainIn           (chain_latch_out),
		.externalCondition (external_condition_wp0),
		.readData          (wp0Read),
		.readHit           (wp0ReadHit),
		.ctlWrite          (),
		.addrMatch         (),
		.ctlMatch          (),
		.dataMatch         (),
		.hit               (wp0Hit)
	);

	// Unit 1 has no partner; its range and chain inputs stay low
	dwc_watch_unit u_wp1
	(
		.core_clk          (core_clk),
		.reset             (reset),
		.scan              (scan),
		.baseAddr          (`DWC_ADDR_WP1_AV),
		.ibus              (ibus),
		.dbus              (dbus),
		.rangeIn           (1'b0),
		.chainIn           (1'b0),
		.externalCondition (external_condition_wp1),
		.readData          (wp1Read),
		.readHit           (wp1ReadHit),
		.ctlWrite          (wp1CtlWrite),
		.addrMatch         (wp1Addr),
		.ctlMatch          (wp1Ctl),
		.dataMatch         (wp1Data),
		.hit               (wp1Hit)
	);

	// Chain latch: cleared by reset or a control write, else loads on address or control match [R6] [R21]
	always_ff @(posedge core_clk)
	begin
		if (reset || wp1CtlWrite)
			chain_latch_out <= 1'b0; // [R6]
		else if (wp1Addr || wp1Ctl)
			chain_latch_out <= wp1Data; // [R5]
	end

	// ------------------------------------------------------------
	// Control, status and vector trap registers
	// ------------------------------------------------------------
	assign wrStrobe = scan.strobe && scan.write;

	// Scan writes; reserved vector bit stays zero [R10] [R16] [R21]
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			debugControl        <= 4'h0;
			exceptionVectorTrap <= 8'h00;
			statusOverride      <= 5'h00;
			statusWritten       <= 1'b0;
		end
		else if (wrStrobe)
		begin
			if (scan.addr == `DWC_ADDR_DBG_CTRL)
				debugControl <= scan.data[3:0]; // [R10]
			else if (scan.addr == `DWC_ADDR_DBG_STAT)
			begin
				statusOverride <= scan.data[4:0]; // [R11]
				statusWritten  <= 1'b1;
			end
			else if (scan.addr == `DWC_ADDR_VEC_TRAP)
				exceptionVectorTrap <= scan.data[7:0]
					& ~(8'h01 << `DWC_VT_RESERVED); // [R16]
		end
	end

	// Two-flop synchronisers for core-side levels
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			syncA   <= 4'h0;
			syncB   <= 4'h0;
			ackPrev <= 1'b0;
		end
		else
		begin
			syncA   <= {compressed_state_flag, system_access_complete,
				debug_request_in, debug_acknowledge};
			syncB   <= syncA;
			ackPrev <= syncB[0];
		end
	end

	// Status composed from the second sync stage and the interrupt-disable control bit [R12] [R13] [R14] [R15]
	// Interrupts count as enabled unless in debug or disabled by control
	assign liveStatus = {syncB[3], syncB[2],
		~(syncB[0] | debugControl[`DWC_DC_INTOFF]), syncB[1], syncB[0]};
	// A written status holds until the next reset
	assign debugStatus = statusWritten ? statusOverride : liveStatus;

	// Local read mux, combinational; registered on read strobes below
	assign localRead =
		(scan.addr == `DWC_ADDR_DBG_CTRL) ? {28'h0000000, debugControl} :
		(scan.addr == `DWC_ADDR_DBG_STAT) ? {27'h0000000, debugStatus} :
		(scan.addr == `DWC_ADDR_VEC_TRAP) ? {24'h000000, exceptionVectorTrap} :
		32'h0000_0000;

	// Read strobe loads local word and which source answers
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			localData  <= `DWC_RST_ZERO32;
			readSelWp0 <= 1'b0;
			readSelWp1 <= 1'b0;
		end
		else if (scan.strobe && !scan.write)
		begin
			localData  <= localRead; // [R11]
			readSelWp0 <= wp0ReadHit;
			readSelWp1 <= wp1ReadHit;
		end
	end

	// All sources are flops that change only on read strobes
	assign scanReadData = readSelWp0 ? wp0Read :
		readSelWp1 ? wp1Read : localData;

	// ------------------------------------------------------------
	// Single step and debug entry
	// ------------------------------------------------------------
	// Step armed in debug, runs one instruction after exit [R19]
	always_comb
	begin
		next_stepState = stepState;
		case (stepState)
			ST_IDLE: if (debugControl[`DWC_DC_STEP] && syncB[0])
				next_stepState = ST_RUN;
			ST_RUN: if (!debugControl[`DWC_DC_STEP])
				next_stepState = ST_IDLE;
			else if (!syncB[0] && instrRetired)
				next_stepState = ST_STOP;
			ST_STOP: if (syncB[0])
				next_stepState = ST_IDLE;
			default: next_stepState = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			stepState <= ST_IDLE;
		else
			stepState <= next_stepState;
	end

	assign stepHit   = stepState == ST_STOP;
	// Only exception-entry fetches are trapped, not branches [R18]
	assign vectorHit = vecFetch.valid && exceptionVectorTrap[vecFetch.vector];
	assign single_step       = debugControl[`DWC_DC_STEP];
	assign interrupt_disable = debugControl[`DWC_DC_INTOFF];
	assign debug_request     = debugControl[`DWC_DC_REQ];
	assign breakpoint = wp0Hit || wp1Hit || vectorHit || stepHit; // [R3]

	// Acknowledge control bit has no pin here; kept for readback only
	logic unusedReads;
	assign unusedReads = ackPrev ^ debugControl[`DWC_DC_ACK];

endmodule : dwc_debug_regs
`default_nettype wire

// ### shared/dwc_map.svh
// Register addresses, field positions and reset values for the debug watch unit
`ifndef DWC_MAP_SVH
`define DWC_MAP_SVH

// Register addresses on the scan chain (5-bit)
`define DWC_ADDR_DBG_CTRL   5'h00
`define DWC_ADDR_DBG_STAT   5'h01
`define DWC_ADDR_VEC_TRAP   5'h02
`define DWC_ADDR_WP0_AV     5'h08
`define DWC_ADDR_WP0_AM     5'h09
`define DWC_ADDR_WP0_DV     5'h0A
`define DWC_ADDR_WP0_DM     5'h0B
`define DWC_ADDR_WP0_CV     5'h0C
`define DWC_ADDR_WP0_CM     5'h0D
`define DWC_ADDR_WP1_AV     5'h10
`define DWC_ADDR_WP1_AM     5'h11
`define DWC_ADDR_WP1_DV     5'h12
`define DWC_ADDR_WP1_DM     5'h13
`define DWC_ADDR_WP1_CV     5'h14
`define DWC_ADDR_WP1_CM     5'h15

// Watchpoint control field positions
`define DWC_CTL_ENABLE      8
`define DWC_CTL_RANGE       7
`define DWC_CTL_CHAIN       6
`define DWC_CTL_EXTERN      5
`define DWC_CTL_NTRANS      4
`define DWC_CTL_DATASEL     3
`define DWC_CTL_ISTATE      1

// Debug control field positions
`define DWC_DC_STEP         3
`define DWC_DC_INTOFF       2
`define DWC_DC_REQ          1
`define DWC_DC_ACK          0

// Debug status field positions
`define DWC_DS_ISTATE       4
`define DWC_DS_SYSDONE      3
`define DWC_DS_INTEN        2
`define DWC_DS_REQ          1
`define DWC_DS_ACK          0

// Vector trap bits: exception codes 0..7 map onto bits 0..7
`define DWC_VT_RESERVED     5

// Reset values
`define DWC_RST_ZERO32      32'h0000_0000

`endif

// ### shared/dwc_pkg.sv
// Types shared by the debug watch unit
`default_nettype none
package dwc_pkg;

	// Core instruction-side bus as seen by the comparators
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic        notTranslate;
		logic        compressed;
	} dwc_ibus_t;

	// Core data-side bus
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic        notTranslate;
		logic [1:0]  size;
		logic        notReadWrite;
	} dwc_dbus_t;

	// Scan access carried to the register file
	typedef struct packed {
		logic        strobe;
		logic        write;
		logic [4:0]  addr;
		logic [31:0] data;
	} dwc_scan_t;

	// Exception-entry fetch marker from the core
	typedef struct packed {
		logic       valid;
		logic [2:0] vector;
	} dwc_vecfetch_t;

endpackage : dwc_pkg
`default_nettype wire

// ### rtl/dwc_watch_unit.sv
// One watchpoint comparator unit with value and mask registers
`timescale 1ns/100ps
`default_nettype none
`include "dwc_map.svh"

module dwc_watch_unit
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire dwc_pkg::dwc_scan_t scan,
	input  wire logic [4:0]        baseAddr,
	input  wire dwc_pkg::dwc_ibus_t ibus,
	input  wire dwc_pkg::dwc_dbus_t dbus,
	input  wire logic              rangeIn,
	input  wire logic              chainIn,
	input  wire logic              externalCondition,
	output logic [31:0]            readData,
	output logic                   readHit,
	output logic                   ctlWrite,
	output logic                   addrMatch,
	output logic                   ctlMatch,
	output logic                   dataMatch,
	output logic                   hit
);

	logic [31:0] addrValue;
	logic [31:0] addrMask;
	logic [31:0] dataValue;
	logic [31:0] dataMask;
	logic [8:0]  ctlValue;
	logic [7:0]  ctlMask;
	logic [4:0]  offs;
	logic        wrStrobe;
	logic        rdStrobe;
	logic        dataSide;
	logic [31:0] busAddr;
	logic [31:0] busData;
	logic [7:0]  busCtl;
	logic [7:0]  ctlDiff;

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	assign offs     = scan.addr - baseAddr;
	assign wrStrobe = scan.strobe && scan.write;
	assign rdStrobe = scan.strobe && !scan.write && readHit;
	assign ctlWrite = wrStrobe && (offs == 5'h04);
	assign readHit  = scan.addr[4:3] == baseAddr[4:3] && offs < 5'h06;

	// Register writes; all clear on reset [R21]
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			addrValue <= `DWC_RST_ZERO32;
			addrMask  <= `DWC_RST_ZERO32;
			dataValue <= `DWC_RST_ZERO32;
			dataMask  <= `DWC_RST_ZERO32;
			ctlValue  <= 9'h000;
			ctlMask   <= 8'h00;
		end
		else if (wrStrobe)
		begin
			if (offs == 5'h00)
				addrValue <= scan.data;
			else if (offs == 5'h01)
				addrMask <= scan.data;
			else if (offs == 5'h02)
				dataValue <= scan.data;
			else if (offs == 5'h03)
				dataMask <= scan.data;
			else if (offs == 5'h04)
				ctlValue <= scan.data[8:0];
			else if (offs == 5'h05)
				ctlMask <= scan.data[7:0];
		end
	end

	// Read mux, registered; loads only on own reads so the word stands
	always_ff @(posedge core_clk)
	begin
		if (reset)
			readData <= `DWC_RST_ZERO32;
		else if (rdStrobe)
		begin
			if (offs == 5'h00)
				readData <= addrValue;
			else if (offs == 5'h01)
				readData <= addrMask;
			else if (offs == 5'h02)
				readData <= dataValue;
			else if (offs == 5'h03)
				readData <= dataMask;
			else if (offs == 5'h04)
				readData <= {23'h000000, ctlValue};
			else
				readData <= {24'h000000, ctlMask};
		end
	end

	// ------------------------------------------------------------
	// Comparison
	// ------------------------------------------------------------
	// Bit 3 low selects the instruction-side buses [R1]
	assign dataSide = ctlValue[`DWC_CTL_DATASEL];
	assign busAddr  = dataSide ? dbus.addr : ibus.addr;
	assign busData  = dataSide ? dbus.data : ibus.data;
	// Ctl bits 4 and 1 carry privilege and state fetch qualifiers [R8] [R9]
	assign busCtl   = dataSide
		? {rangeIn, chainIn, externalCondition, dbus.notTranslate,
			1'b1, dbus.size, dbus.notReadWrite}
		: {rangeIn, chainIn, externalCondition, ibus.notTranslate,
			1'b0, 1'b0, ibus.compressed, 1'b0};
	// Qualifiers 7..5 compare range, chain and external inputs [R7]
	// Bit 3 is never masked; mask 1 ignores a bit [R17]
	assign ctlDiff  = (busCtl ^ ctlValue[7:0])
		& ~(ctlMask & 8'hF7);
	assign addrMatch = ((busAddr ^ addrValue) & ~addrMask) == 32'h0;
	assign dataMatch = ((busData ^ dataValue) & ~dataMask) == 32'h0;
	assign ctlMatch  = ctlDiff == 8'h00;
	// Every unmasked field must agree; enable gates the output [R20] [R3]
	assign hit = addrMatch && dataMatch && ctlMatch
		&& ctlValue[`DWC_CTL_ENABLE];

endmodule : dwc_watch_unit
`default_nettype wire

// ### tb/dwc_debug_regs_asserts.sv
// Concurrent checks on the debug register block ports
`timescale 1ns/100ps
`default_nettype none

module dwc_debug_regs_asserts
(
	input wire logic               core_clk,
	input wire logic               reset,
	input wire dwc_pkg::dwc_scan_t scan,
	input wire logic [31:0]        scanReadData,
	input wire logic               system_access_complete,
	input wire logic               compressed_state_flag,
	input wire logic               debug_request,
	input wire logic               interrupt_disable,
	input wire logic               single_step,
	input wire logic               chain_latch_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// --------------------
	// Access decode
	// --------------------
	// One name per watched access
	wire wrCtl  = scan.strobe && scan.write && scan.addr == 5'h00;
	wire rdCtl  = scan.strobe && !scan.write && scan.addr == 5'h00;
	wire wrStat = scan.strobe && scan.write && scan.addr == 5'h01;
	wire rdStat = scan.strobe && !scan.write && scan.addr == 5'h01;
	wire rdVec  = scan.strobe && !scan.write && scan.addr == 5'h02;
	wire wrCv1  = scan.strobe && scan.write && scan.addr == 5'h14;
	logic ovr;

	// A status write overrides the flags until reset, so sync checks stop
	always_ff @(posedge core_clk)
		if (reset)
			ovr <= 1'h0;
		else if (wrStat)
			ovr <= 1'h1;

	a_step_bit:
		assert property (wrCtl |=> single_step == $past(scan.data[3]))
		else $error("step bit not loaded");
	a_interrupt_disable_bit:
		assert property (wrCtl |=> interrupt_disable == $past(scan.data[2]))
		else $error("interrupt disable bit not loaded");
	a_request_bit:
		assert property (wrCtl |=> debug_request == $past(scan.data[1]))
		else $error("request bit not loaded");
	a_ctl_readback:
		assert property (rdCtl |=> scanReadData[3:1] ==
			$past({single_step, interrupt_disable, debug_request}))
		else $error("control read differs from outputs");
	a_chain_clear:
		assert property (wrCv1 |=> !chain_latch_out)
		else $error("chain latch not cleared");
	a_reset_clear:
		assert property ($fell(reset) |-> !(chain_latch_out ||
			debug_request || single_step || interrupt_disable))
		else $error("outputs not cleared by reset");
	a_vec_reserved:
		assert property (rdVec |=> !scanReadData[5])
		else $error("reserved vector bit reads one");
	a_status_sync:
		assert property ($stable({compressed_state_flag,
			system_access_complete})[*4] ##0 (rdStat && !ovr) |=>
			scanReadData[4:3] == $past({compressed_state_flag,
			system_access_complete}))
		else $error("status misses core flags");
	a_status_write:
		assert property (wrStat ##2 rdStat |=>
			scanReadData[4:0] == $past(scan.data[4:0], 3))
		else $error("status write not read back");
endmodule : dwc_debug_regs_asserts

bind dwc_debug_regs dwc_debug_regs_asserts u_dwc_debug_regs_asserts
(
	.core_clk, .reset, .scan, .scanReadData, .system_access_complete,
	.compressed_state_flag, .debug_request, .interrupt_disable,
	.single_step, .chain_latch_out
);

`default_nettype wire

// ### tb/dwc_core_model.sv
// Behavioural processor core facing the debug register block
`timescale 1ns/100ps
`default_nettype none

module dwc_core_model
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              breakpoint,
	input  wire logic              debug_request,
	input  wire logic              runReq,
	output var dwc_pkg::dwc_ibus_t ibus,
	output logic                   instrRetired,
	output logic                   debug_acknowledge
);
	logic [31:0] pc;
	logic        halted;

	// --------------------
	// Fetch and halt
	// --------------------
	// Halt wins over resume so a pending stop is never lost
	always_ff @(posedge core_clk)
		if (reset)
		begin
			pc     <= 32'h0000_0000;
			halted <= 1'h0;
		end
		else if (breakpoint || debug_request)
			halted <= 1'h1;
		else if (runReq)
			halted <= 1'h0;
		else if (!halted)
			pc <= pc + 32'h0000_0004;

	// Privileged normal-state fetches only; data is the inverted pc
	assign ibus = '{addr: pc, data: ~pc, notTranslate: 1'h1,
		compressed: 1'h0};
	assign instrRetired      = !halted;
	assign debug_acknowledge = halted;
endmodule : dwc_core_model

`default_nettype wire

// ### tb/dwc_debug_regs_bench.sv
// Self-checking bench for the debug register block
`timescale 1ns/100ps
`default_nettype none

module dwc_debug_regs_bench;
	typedef struct packed
	{
		logic [4:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} dwc_row_t;

	logic                   core_clk;
	logic                   reset;
	logic                   runReq;
	logic                   system_access_complete;
	logic                   compressed_state_flag;
	logic                   external_condition_wp0;
	logic                   instrRetired;
	logic                   debug_acknowledge;
	logic                   debug_request;
	logic                   breakpoint;
	logic [31:0]            scanReadData;
	logic [31:0]            rd;
	dwc_pkg::dwc_scan_t     scan;
	dwc_pkg::dwc_ibus_t     ibus;
	dwc_pkg::dwc_vecfetch_t vecFetch;
	int                     failures;
	int                     total_checks;

	// Write then read back; width limits and reserved bits show here
	dwc_row_t rows [9] = '{
		'{5'h00, 32'h0000_000F, 32'h0000_000F},
		'{5'h02, 32'h0000_00FF, 32'h0000_00DF},
		'{5'h08, 32'h1234_5678, 32'h1234_5678},
		'{5'h11, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
		'{5'h0D, 32'h0000_01FF, 32'h0000_00FF},
		'{5'h0C, 32'h0000_03FF, 32'h0000_01FF},
		'{5'h14, 32'h0000_0000, 32'h0000_0000},
		'{5'h03, 32'hFFFF_FFFF, 32'h0000_0000},
		'{5'h00, 32'h0000_0000, 32'h0000_0000}
	};

	dwc_debug_regs u_dwc_debug_regs
	(
		.core_clk, .reset, .scan, .scanReadData, .ibus, .vecFetch,
		.dbus                   ('0),
		.instrRetired, .system_access_complete, .compressed_state_flag,
		.external_condition_wp0,
		.external_condition_wp1 (1'h0),
		.debug_request_in       (debug_request),
		.debug_acknowledge, .debug_request, .breakpoint,
		.interrupt_disable      (),
		.single_step            (),
		.chain_latch_out        ()
	);

	dwc_core_model u_dwc_core_model
	(
		.core_clk, .reset, .breakpoint, .debug_request, .runReq, .ibus,
		.instrRetired, .debug_acknowledge
	);

	// --------------------
	// Helpers
	// --------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// Drives on an edge, taken on the next; calls leave one idle cycle
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		scan <= '{1'h1, w, a, d};
		@(posedge core_clk);
		scan.strobe <= 1'h0;
		#1 rd = scanReadData;
	endtask : acc

	// Resume the core, then wait a bounded time for it to stop again
	task automatic run_until_halt(input int limit);
		int n;
		n = 0;
		@(posedge core_clk);
		runReq <= 1'h1;
		@(posedge core_clk);
		runReq <= 1'h0;
		#1;
		while (debug_acknowledge !== 1'h1 && n < limit)
		begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask : run_until_halt

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial
	begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end

	// Whole run is just over a thousand cycles
	initial
	begin
		#200000;
		failures++;
		final_report();
	end

	// --------------------
	// Main sequence
	// --------------------
	initial
	begin
		failures = 0;
		total_checks = 0;
		reset = 1'h1;
		runReq = 1'h0;
		system_access_complete = 1'h0;
		compressed_state_flag = 1'h0;
		external_condition_wp0 = 1'h0;
		scan = '0;
		vecFetch = '0;
		repeat (8) @(posedge core_clk);
		reset <= 1'h0;
		acc(1'h0, 5'h00, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		acc(1'h0, 5'h01, 32'h0000_0000);
		check(rd, 32'h0000_0004);
		@(posedge core_clk);
		system_access_complete <= 1'h1;
		compressed_state_flag <= 1'h1;
		repeat (4) @(posedge core_clk);
		acc(1'h0, 5'h01, 32'h0000_0000);
		check(rd, 32'h0000_001C);
		foreach (rows[i])
		begin
			acc(1'h1, rows[i].a, rows[i].d);
			acc(1'h0, rows[i].a, 32'h0000_0000);
			check(rd, rows[i].e);
		end
		// Core halted by the request bit, so acknowledge is now high
		acc(1'h0, 5'h01, 32'h0000_0000);
		check(rd, 32'h0000_0019);
		// Request bit comes back through its synchroniser
		acc(1'h1, 5'h00, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		acc(1'h0, 5'h01, 32'h0000_0000);
		check(rd, 32'h0000_001B);
		acc(1'h1, 5'h00, 32'h0000_0000);
		// Privileged fetch watch; low mask bits set as required
		acc(1'h1, 5'h08, 32'h0000_1000);
		acc(1'h1, 5'h09, 32'h0000_0000);
		acc(1'h1, 5'h0B, 32'hFFFF_FFFF);
		acc(1'h1, 5'h0D, 32'h0000_00E7);
		acc(1'h1, 5'h0C, 32'h0000_0110);
		run_until_halt(3000);
		check(ibus.addr, 32'h0000_1000);
		// Only the software interrupt vector may stop the core
		acc(1'h1, 5'h0C, 32'h0000_0000);
		acc(1'h1, 5'h02, 32'h0000_0004);
		for (int v = 0; v < 8; v++)
		begin
			@(posedge core_clk);
			vecFetch <= '{1'h1, v[2:0]};
			#1 check({31'h0, breakpoint}, {31'h0, v == 2});
		end
		@(posedge core_clk);
		vecFetch <= '0;
		// Only the external condition decides; all else masked except ctl bit 3, which still compares and matches the instruction side
		acc(1'h1, 5'h09, 32'hFFFF_FFFF);
		acc(1'h1, 5'h0D, 32'h0000_00D7);
		acc(1'h1, 5'h0C, 32'h0000_0120);
		for (int x = 0; x < 2; x++)
		begin
			@(posedge core_clk);
			external_condition_wp0 <= x[0];
			#1 check({31'h0, breakpoint}, x);
		end
		@(posedge core_clk);
		external_condition_wp0 <= 1'h0;
		acc(1'h1, 5'h0C, 32'h0000_0000);
		acc(1'h1, 5'h02, 32'h0000_0000);
		acc(1'h1, 5'h00, 32'h0000_0008);
		run_until_halt(20);
		check({31'h0, debug_acknowledge}, 32'h0000_0001);
		acc(1'h1, 5'h00, 32'h0000_0000);
		acc(1'h1, 5'h01, 32'h0000_0015);
		acc(1'h0, 5'h01, 32'h0000_0000);
		check(rd, 32'h0000_0015);
		// Second reset drops the override
		@(posedge core_clk);
		reset <= 1'h1;
		repeat (2) @(posedge core_clk);
		reset <= 1'h0;
		repeat (4) @(posedge core_clk);
		acc(1'h0, 5'h01, 32'h0000_0000);
		check(rd, 32'h0000_001C);
		final_report();
	end
endmodule : dwc_debug_regs_bench

`default_nettype wire
